// ===== hdl/audio_guard_ctrl.sv
// host controller that changes guarded audio port fields in a safe order
`timescale 1ns/10ps
`include "audio_guard_regs.svh"
module audio_guard_ctrl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] m_axi_awaddr,
  output logic m_axi_awvalid,
  input wire logic m_axi_awready,
  output logic [31:0] m_axi_wdata,
  output logic [3:0] m_axi_wstrb,
  output logic m_axi_wvalid,
  input wire logic m_axi_wready,
  input wire logic [1:0] m_axi_bresp,
  input wire logic m_axi_bvalid,
  output logic m_axi_bready,
  output logic [31:0] m_axi_araddr,
  output logic m_axi_arvalid,
  input wire logic m_axi_arready,
  input wire logic [31:0] m_axi_rdata,
  input wire logic [1:0] m_axi_rresp,
  input wire logic m_axi_rvalid,
  output logic m_axi_rready
);
  import audio_guard_pkg::*;
  master_type s;
  master_type n;
  logic [1:0] rstSync;
  logic rstn;
  logic go;
  audio_guard_pkg::field_type goField;
  logic [31:0] goData;
  logic [31:0] need;

  // ==========================================
  // reset release
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstn = rstSync[1];

  // ==========================================
  // release bits each guarded field needs
  function automatic logic [31:0] needBits(input field_type f);
    logic [31:0] m;
    m = 32'h0;
    case (f)
      F_SPDIF_EN: m = `TX_SM_MASK | `TX_FS_MASK;
      F_TX_SLOT_SIZE: m = `TX_SM_MASK;
      F_TX_DATA_DELAY: m = `RX_SM_MASK | `TX_SM_MASK;
      F_RX_SLOT_SIZE, F_RX_DATA_DELAY: m = `RX_SM_MASK;
      F_TX_FS: m = `TX_SM_MASK | `TX_FS_MASK;
      F_RX_FS, F_CLK_INDEP: m = `RX_SM_MASK | `RX_FS_MASK;
      F_TX_BCLK_DIV: m = `TX_CG_MASK | `TX_SC_MASK | `TX_SM_MASK | `TX_FS_MASK;
      F_TX_BCLK_MODE: m = `TX_SC_MASK | `TX_SM_MASK | `TX_FS_MASK;
      F_RX_BCLK_DIV: m = `RX_CG_MASK | `RX_SC_MASK | `RX_SM_MASK | `RX_FS_MASK;
      F_RX_BCLK_MODE: m = `RX_SC_MASK | `RX_SM_MASK | `RX_FS_MASK;
      F_TX_HICLK: m = `TX_HC_MASK | `TX_CG_MASK | `TX_SC_MASK | `TX_SM_MASK | `TX_FS_MASK;
      F_RX_HICLK: m = `RX_HC_MASK | `RX_CG_MASK | `RX_SC_MASK | `RX_SM_MASK | `RX_FS_MASK;
      F_LOOPBACK: m = `RX_SC_MASK | `RX_SM_MASK | `RX_FS_MASK
                      | `TX_SC_MASK | `TX_SM_MASK | `TX_FS_MASK;
      default: m = 32'h0;
    endcase
    return m;
  endfunction

  // ==========================================
  // device register holding each field
  function automatic logic [31:0] regOf(input field_type f);
    logic [31:0] a;
    a = `GBL_OFF;
    case (f)
      F_SPDIF_EN: a = `SPDIF_OFF;
      F_TX_SLOT_SIZE, F_TX_DATA_DELAY: a = `TX_FMT_OFF;
      F_RX_SLOT_SIZE, F_RX_DATA_DELAY: a = `RX_FMT_OFF;
      F_TX_FS: a = `TX_FS_OFF;
      F_RX_FS: a = `RX_FS_OFF;
      F_CLK_INDEP, F_TX_BCLK_DIV, F_TX_BCLK_MODE: a = `TX_BCLK_OFF;
      F_RX_BCLK_DIV, F_RX_BCLK_MODE: a = `RX_BCLK_OFF;
      F_TX_HICLK: a = `TX_HCLK_OFF;
      F_RX_HICLK: a = `RX_HCLK_OFF;
      F_LOOPBACK: a = `LOOP_OFF;
      default: a = `GBL_OFF;
    endcase
    return a;
  endfunction

  assign need = needBits(s.field);

  // ==========================================
  // command registers
  sw_cmd_regs cmdRegs (
    .clock(clock),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .goField(goField),
    .goData(goData),
    .go(go),
    .busy(s.busy),
    .done(s.done),
    .err(s.err),
    .gblSnap(s.gblSnap)
  );

  // ==========================================
  // sequencer and bus master
  always_comb
  begin
    n = s;
    n.wstrb = `STRB_ALL;
    if (s.arvalid && m_axi_arready)
      n.arvalid = 1'b0;
    if (s.awvalid && m_axi_awready)
      n.awvalid = 1'b0;
    if (s.wvalid && m_axi_wready)
      n.wvalid = 1'b0;
    case (s.state)
      S_IDLE:
      begin
        if (go)
        begin
          n.done = 1'b0;
          n.err = goField == F_INVALID;
          n.field = goField;
          n.value = goData;
          n.triedSet = 1'b0;
          if (goField != F_INVALID)
          begin
            n.busy = 1'b1;
            n.state = S_READ_GBL;
            n.arvalid = 1'b1;
            n.rready = 1'b1;
            n.araddr = `GBL_OFF;
          end
        end
      end
      S_READ_GBL:
      begin
        if (s.rready && m_axi_rvalid)
        begin
          n.rready = 1'b0;
          n.gblSnap = m_axi_rdata;
          if (m_axi_rresp[1] || (s.triedSet && (m_axi_rdata & need) != need))
          begin
            n.err = 1'b1;
            n.busy = 1'b0;
            n.state = S_IDLE;
          end
          else if ((m_axi_rdata & need) == need)
          begin
            n.state = S_WRITE_FIELD;
            n.awvalid = 1'b1;
            n.wvalid = 1'b1;
            n.bready = 1'b1;
            n.awaddr = regOf(s.field);
            n.wdata = s.value;
          end
          else
          begin
            n.state = S_WRITE_GBL;
            n.awvalid = 1'b1;
            n.wvalid = 1'b1;
            n.bready = 1'b1;
            n.awaddr = `GBL_OFF;
            n.wdata = m_axi_rdata | need;
          end
        end
      end
      S_WRITE_GBL, S_WRITE_FIELD:
      begin
        if (s.bready && m_axi_bvalid)
        begin
          n.bready = 1'b0;
          if (m_axi_bresp[1])
          begin
            n.err = 1'b1;
            n.busy = 1'b0;
            n.state = S_IDLE;
          end
          else if (s.state == S_WRITE_GBL)
          begin
            n.triedSet = 1'b1;
            n.state = S_READ_GBL;
            n.arvalid = 1'b1;
            n.rready = 1'b1;
            n.araddr = `GBL_OFF;
          end
          else
          begin
            n.done = 1'b1;
            n.busy = 1'b0;
            n.state = S_IDLE;
          end
        end
      end
      default: n.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= n;
  end

  assign m_axi_awaddr = s.awaddr;
  assign m_axi_awvalid = s.awvalid;
  assign m_axi_wdata = s.wdata;
  assign m_axi_wstrb = s.wstrb;
  assign m_axi_wvalid = s.wvalid;
  assign m_axi_bready = s.bready;
  assign m_axi_araddr = s.araddr;
  assign m_axi_arvalid = s.arvalid;
  assign m_axi_rready = s.rready;

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence gblReadDone;
    s.state == S_READ_GBL && s.rready && m_axi_rvalid;
  endsequence
  sequence fieldIssued;
    s.state == S_WRITE_FIELD && s.awvalid;
  endsequence

  chk_field_gated: assert property (fieldIssued |-> (s.gblSnap & need) == need)
    else $error("field write without release bits");
  chk_retry_fail: assert property (gblReadDone
    ##0 (s.triedSet && (m_axi_rdata & need) != need)
    |=> s.err && s.state == S_IDLE && !s.awvalid)
    else $error("unconfirmed release did not abort");
  chk_gbl_only: assert property (s.arvalid |-> s.araddr == `GBL_OFF)
    else $error("readiness read from wrong register");
  chk_set_first: assert property (s.state == S_WRITE_GBL && s.wvalid
    |-> (s.wdata & need) == need && (s.wdata & s.gblSnap) == s.gblSnap)
    else $error("release write misses bits");
  chk_spdif_need: assert property (s.field == F_SPDIF_EN
    |-> need == (`TX_SM_MASK | `TX_FS_MASK))
    else $error("spdif enable release set wrong");
  chk_slot_need: assert property (s.field == F_TX_SLOT_SIZE |-> need == `TX_SM_MASK)
    else $error("tx slot release set wrong");
  chk_txdly_gated: assert property (fieldIssued ##0 s.field == F_TX_DATA_DELAY
    |-> (s.gblSnap & 32'h0000_0808) == 32'h0000_0808)
    else $error("tx data delay write too early");
  chk_rxfmt_gated: assert property (fieldIssued
    ##0 (s.field == F_RX_SLOT_SIZE || s.field == F_RX_DATA_DELAY)
    |-> (s.gblSnap & 32'h0000_0008) == 32'h0000_0008)
    else $error("rx format write too early");
  chk_txfs_gated: assert property (fieldIssued ##0 s.field == F_TX_FS
    |-> (s.gblSnap & 32'h0000_1800) == 32'h0000_1800)
    else $error("tx frame sync write too early");
  chk_rxfs_gated: assert property (fieldIssued
    ##0 (s.field == F_RX_FS || s.field == F_CLK_INDEP)
    |-> (s.gblSnap & 32'h0000_0018) == 32'h0000_0018)
    else $error("rx frame sync write too early");
  chk_bclk_need: assert property (s.field == F_TX_BCLK_DIV
    |-> need == (`TX_CG_MASK | `TX_SC_MASK | `TX_SM_MASK | `TX_FS_MASK))
    else $error("tx bit clock release set wrong");
  chk_txmode_gated: assert property (fieldIssued ##0 s.field == F_TX_BCLK_MODE
    |-> (s.gblSnap & 32'h0000_1C00) == 32'h0000_1C00)
    else $error("tx bit clock mode write too early");
  chk_rxdiv_gated: assert property (fieldIssued ##0 s.field == F_RX_BCLK_DIV
    |-> (s.gblSnap & 32'h0000_001E) == 32'h0000_001E)
    else $error("rx bit clock divider write too early");
  chk_rxmode_gated: assert property (fieldIssued ##0 s.field == F_RX_BCLK_MODE
    |-> (s.gblSnap & 32'h0000_001C) == 32'h0000_001C)
    else $error("rx bit clock mode write too early");
  chk_txhi_gated: assert property (fieldIssued ##0 s.field == F_TX_HICLK
    |-> (s.gblSnap & 32'h0000_1F00) == 32'h0000_1F00)
    else $error("tx high clock write too early");
  chk_hiclk_need: assert property (fieldIssued ##0 s.field == F_RX_HICLK
    |-> (s.gblSnap & 32'h0000_001F) == 32'h0000_001F)
    else $error("rx high clock write too early");
  chk_loop_need: assert property (s.field == F_LOOPBACK
    |-> need == 32'h0000_1C1C)
    else $error("loopback release set wrong");
  chk_readback_first: assert property ($rose(s.state == S_WRITE_FIELD)
    |-> $past(s.rready) && $past(m_axi_rvalid))
    else $error("field write not preceded by readback");
  chk_done_resp: assert property ($rose(s.done)
    |-> $past(s.state) == S_WRITE_FIELD && $past(m_axi_bvalid))
    else $error("done without field write response");
  chk_aw_hold: assert property (s.awvalid && !m_axi_awready
    |=> s.awvalid && $stable(s.awaddr))
    else $error("write address dropped before taken");
endmodule

// ===== hdl/audio_guard_regs.svh
// register offsets, field positions and masks for the configuration guard
`ifndef AUDIO_GUARD_REGS_SVH
`define AUDIO_GUARD_REGS_SVH
// ==========================================
// device register offsets (device side of the controller)
`define GBL_OFF 32'h0000_0000
`define SPDIF_OFF 32'h0000_0004
`define TX_FMT_OFF 32'h0000_0008
`define RX_FMT_OFF 32'h0000_000C
`define TX_FS_OFF 32'h0000_0010
`define RX_FS_OFF 32'h0000_0014
`define TX_BCLK_OFF 32'h0000_0018
`define RX_BCLK_OFF 32'h0000_001C
`define TX_HCLK_OFF 32'h0000_0020
`define RX_HCLK_OFF 32'h0000_0024
`define LOOP_OFF 32'h0000_0028
// ==========================================
// global control release bits
`define RX_HC_MASK 32'h0000_0001
`define RX_CG_MASK 32'h0000_0002
`define RX_SC_MASK 32'h0000_0004
`define RX_SM_MASK 32'h0000_0008
`define RX_FS_MASK 32'h0000_0010
`define TX_HC_MASK 32'h0000_0100
`define TX_CG_MASK 32'h0000_0200
`define TX_SC_MASK 32'h0000_0400
`define TX_SM_MASK 32'h0000_0800
`define TX_FS_MASK 32'h0000_1000
// ==========================================
// software command registers
`define CMD_FIELD_OFF 32'h0000_0000
`define CMD_DATA_OFF 32'h0000_0004
`define CMD_CTRL_OFF 32'h0000_0008
`define CMD_SNAP_OFF 32'h0000_000C
`define CTRL_GO_BIT 0
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_ERR_BIT 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_ALL 4'hF
`endif

// ===== hdl/audio_guard_pkg.sv
// types shared by the configuration guard controller
package audio_guard_pkg;
  typedef enum logic [3:0] {
    F_SPDIF_EN = 4'h0, F_TX_SLOT_SIZE = 4'h1, F_TX_DATA_DELAY = 4'h2,
    F_RX_SLOT_SIZE = 4'h3, F_RX_DATA_DELAY = 4'h4, F_TX_FS = 4'h5, F_RX_FS = 4'h6,
    F_CLK_INDEP = 4'h7, F_TX_BCLK_DIV = 4'h8, F_TX_BCLK_MODE = 4'h9,
    F_RX_BCLK_DIV = 4'hA, F_RX_BCLK_MODE = 4'hB, F_TX_HICLK = 4'hC,
    F_RX_HICLK = 4'hD, F_LOOPBACK = 4'hE, F_INVALID = 4'hF
  } field_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_READ_GBL = 2'b01, S_WRITE_GBL = 2'b10, S_WRITE_FIELD = 2'b11
  } state_type;
  typedef struct packed {
    state_type state;
    field_type field;
    logic [31:0] value;
    logic [31:0] gblSnap;
    logic triedSet;
    logic busy;
    logic done;
    logic err;
    logic awvalid;
    logic wvalid;
    logic bready;
    logic arvalid;
    logic rready;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] araddr;
  } master_type;
  typedef struct packed {
    logic awHave;
    logic wHave;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    field_type field;
    logic [31:0] data;
    logic go;
  } slave_type;
endpackage

// ===== hdl/sw_cmd_regs.sv
// axi4-lite slave holding the software command and status registers
`timescale 1ns/10ps
`include "audio_guard_regs.svh"
module sw_cmd_regs (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output audio_guard_pkg::field_type goField,
  output logic [31:0] goData,
  output logic go,
  input wire logic busy,
  input wire logic done,
  input wire logic err,
  input wire logic [31:0] gblSnap
);
  import audio_guard_pkg::*;
  slave_type s;
  slave_type n;
  logic [31:0] merged;

  // ==========================================
  // byte lane merge
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ==========================================
  // next state
  always_comb
  begin
    n = s;
    n.go = 1'b0;
    merged = 32'h0;
    if (s_axi_awvalid && s.awready)
    begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (n.awHave && n.wHave && !n.bvalid)
    begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (n.awAddr)
        `CMD_FIELD_OFF:
        begin
          merged = laneMerge({28'h0, s.field}, n.wData, n.wStrb);
          n.field = field_type'(merged[3:0]);
        end
        `CMD_DATA_OFF: n.data = laneMerge(s.data, n.wData, n.wStrb);
        `CMD_CTRL_OFF: n.go = n.wData[`CTRL_GO_BIT] && n.wStrb[0] && !busy;
        `CMD_SNAP_OFF: n.bresp = `RESP_OKAY;
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = 32'h0;
      case (s_axi_araddr)
        `CMD_FIELD_OFF: n.rdata = {28'h0, s.field};
        `CMD_DATA_OFF: n.rdata = s.data;
        `CMD_CTRL_OFF:
        begin
          n.rdata[`ST_BUSY_BIT] = busy;
          n.rdata[`ST_DONE_BIT] = done;
          n.rdata[`ST_ERR_BIT] = err;
        end
        `CMD_SNAP_OFF: n.rdata = gblSnap;
        default: n.rresp = `RESP_SLVERR;
      endcase
    end
    n.awready = !n.awHave && !n.bvalid;
    n.wready = !n.wHave && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= n;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign goField = s.field;
  assign goData = s.data;
  assign go = s.go;
endmodule

// ===== dv/dev_port_model.sv
// behavioural audio port register file answering the controller's device bus
`timescale 1ns/10ps
module dev_port_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic slow,
  input wire logic errResp,
  input wire logic preset,
  input wire logic [31:0] presetVal,
  input wire logic [31:0] stuckMask,
  output logic [31:0] gbl,
  output logic [31:0] fieldAddr,
  output logic [31:0] fieldData,
  output logic [31:0] gblAtWrite,
  output int fieldWrites
);
  // ==========================================
  // register file and slave channels
  logic [31:0] regs [0:10];
  logic [31:0] aAddr, wDat;
  logic aHave, wHave;
  logic [3:0] tick;
  assign gbl = regs[0];
  assign awready = !aHave && (!slow || tick[1:0] == 2'h0);
  assign wready = !wHave && (!slow || tick[1:0] == 2'h1);
  assign arready = !rvalid && (!slow || tick[1:0] == 2'h2);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 11; i++)
        regs[i] <= 32'h0;
      {aHave, wHave, bvalid, rvalid, tick} <= '0;
      {aAddr, wDat, bresp, rresp, rdata} <= '0;
      {fieldAddr, fieldData, gblAtWrite} <= '0;
      fieldWrites <= 0;
    end
    else
    begin
      tick <= tick + 4'h1;
      if (preset)
        regs[0] <= presetVal;
      if (awvalid && awready)
        aAddr <= awaddr;
      if (awvalid && awready)
        aHave <= 1'b1;
      if (wvalid && wready)
        wDat <= wdata;
      if (wvalid && wready)
        wHave <= 1'b1;
      if (aHave && wHave && !bvalid)
      begin
        bvalid <= 1'b1;
        bresp <= (errResp || aAddr > 32'h28) ? 2'h2 : 2'h0;
        if (!errResp && aAddr == 32'h0)
          regs[0] <= wDat & ~stuckMask;
        else if (!errResp && aAddr <= 32'h28)
        begin
          regs[aAddr[5:2]] <= wDat;
          fieldAddr <= aAddr;
          fieldData <= wDat;
          gblAtWrite <= regs[0];
          fieldWrites <= fieldWrites + 1;
        end
      end
      if (bvalid && bready)
        {bvalid, aHave, wHave} <= '0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= (errResp || araddr > 32'h28) ? 2'h2 : 2'h0;
        rdata <= (araddr <= 32'h28) ? regs[araddr[5:2]] : 32'h0;
      end
      else
      begin
        if (rready)
          rvalid <= 1'b0;
        if (!rvalid || rready)
          rdata <= ~rdata;
      end
    end
  end
endmodule

// ===== dv/audio_guard_ctrl_tb.sv
// self-checking bench for the configuration guard controller
`timescale 1ns/10ps
`include "audio_guard_regs.svh"
module audio_guard_ctrl_tb;
  // ==========================================
  // signals
  logic clock;
  logic resetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, presetVal = '0, stuckMask = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic slow = 1'b0, errResp = 1'b0, preset = 1'b0;
  logic [3:0] wstrb = `STRB_ALL;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, mBresp, mRresp;
  logic [31:0] rdata, mAwaddr, mWdata, mAraddr, mRdata, gbl, fieldAddr, fieldData, gblAtWrite;
  logic [3:0] mWstrb;
  logic mAwvalid, mAwready, mWvalid, mWready, mBvalid, mBready;
  logic mArvalid, mArready, mRvalid, mRready;
  int fieldWrites, cycles = 0, failures = 0, n_compared = 0;
  logic [31:0] offTab [0:14] = '{32'h04, 32'h08, 32'h08, 32'h0C, 32'h0C, 32'h10, 32'h14,
    32'h18, 32'h18, 32'h18, 32'h1C, 32'h1C, 32'h20, 32'h24, 32'h28};
  logic [31:0] needTab [0:14] = '{
    32'h1800,
    32'h0800,
    32'h0808,
    32'h0008,
    32'h0008,
    32'h1800,
    32'h0018,
    32'h0018,
    32'h1E00,
    32'h1C00,
    32'h001E,
    32'h001C,
    32'h1F00,
    32'h001F,
    32'h1C1C};
  audio_guard_ctrl dut (.clock(clock), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .m_axi_awaddr(mAwaddr), .m_axi_awvalid(mAwvalid), .m_axi_awready(mAwready),
    .m_axi_wdata(mWdata), .m_axi_wstrb(mWstrb), .m_axi_wvalid(mWvalid),
    .m_axi_wready(mWready), .m_axi_bresp(mBresp), .m_axi_bvalid(mBvalid),
    .m_axi_bready(mBready), .m_axi_araddr(mAraddr), .m_axi_arvalid(mArvalid),
    .m_axi_arready(mArready), .m_axi_rdata(mRdata), .m_axi_rresp(mRresp),
    .m_axi_rvalid(mRvalid), .m_axi_rready(mRready));
  dev_port_model dev (.clock(clock), .resetn(resetn), .awaddr(mAwaddr), .awvalid(mAwvalid),
    .awready(mAwready), .wdata(mWdata), .wvalid(mWvalid), .wready(mWready), .bresp(mBresp),
    .bvalid(mBvalid), .bready(mBready), .araddr(mAraddr), .arvalid(mArvalid),
    .arready(mArready), .rdata(mRdata), .rresp(mRresp), .rvalid(mRvalid), .rready(mRready),
    .slow(slow), .errResp(errResp), .preset(preset), .presetVal(presetVal),
    .stuckMask(stuckMask), .gbl(gbl), .fieldAddr(fieldAddr), .fieldData(fieldData),
    .gblAtWrite(gblAtWrite), .fieldWrites(fieldWrites));
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awSeen, wSeen, bSeen;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clock);
      awSeen = awready === 1'b1;
      wSeen = wready === 1'b1;
      bSeen = bvalid === 1'b1;
      r = bresp;
      @(posedge clock);
      if (awSeen)
        awvalid <= 1'b0;
      if (wSeen)
        wvalid <= 1'b0;
    end
    while (!bSeen);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arSeen, rSeen;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clock);
      arSeen = arready === 1'b1;
      rSeen = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (arSeen)
        arvalid <= 1'b0;
    end
    while (!rSeen);
    rready <= 1'b0;
  endtask
  task automatic run_cmd(input logic [3:0] f, input logic [31:0] d, input logic [31:0] g,
    input logic [31:0] s, input logic e);
    logic [31:0] need, g2, st;
    logic [1:0] r;
    logic okExp;
    int wBefore, k;
    @(posedge clock);
    preset <= 1'b1;
    presetVal <= g;
    stuckMask <= s;
    errResp <= e;
    slow <= 1'($urandom);
    @(posedge clock);
    preset <= 1'b0;
    wBefore = fieldWrites;
    axi_write(`CMD_FIELD_OFF, {28'h0, f}, r);
    axi_write(`CMD_DATA_OFF, d, r);
    axi_write(`CMD_CTRL_OFF, 32'h1, r);
    check("ctrl bresp", {30'h0, r}, {30'h0, `RESP_OKAY});
    repeat (3) @(posedge clock);
    k = 0;
    do
    begin
      axi_read(`CMD_CTRL_OFF, st, r);
      k++;
    end
    while (st[`ST_BUSY_BIT] !== 1'b0 && k < 500);
    need = (f == 4'hF) ? 32'h0 : needTab[f];
    g2 = ((g & need) == need || e) ? g : ((g | need) & ~s);
    okExp = f != 4'hF && !e && (g2 & need) == need;
    check("done", {31'h0, st[`ST_DONE_BIT]}, {31'h0, okExp});
    check("err", {31'h0, st[`ST_ERR_BIT]}, {31'h0, !okExp});
    check("field writes", 32'(fieldWrites - wBefore), {31'h0, okExp});
    check("gbl", gbl, g2);
    check("wstrb", {28'h0, mWstrb}, {28'h0, `STRB_ALL});
    if (f != 4'hF && !e)
    begin
      axi_read(`CMD_SNAP_OFF, st, r);
      check("snap", st, g2);
    end
    if (okExp)
    begin
      check("field addr", fieldAddr, offTab[f]);
      check("field data", fieldData, d);
      check("gbl at write", gblAtWrite & need, need);
    end
  endtask
  // ==========================================
  // clock, timeout and main sequence
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    logic [31:0] v, v2;
    logic [1:0] r;
    void'($urandom(32'h00129593));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 48; i++)
      run_cmd(4'(i), $urandom, $urandom & 32'h1F1F, (i >= 32) ? ($urandom & 32'h1F1F) : 32'h0,
        i == 46);
    axi_read(32'h0000_0040, v, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    check("unmapped rdata", v, 32'h0);
    axi_write(32'h0000_0002, 32'hFFFF_FFFF, r);
    check("unaligned bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_read(`CMD_SNAP_OFF, v, r);
    axi_write(`CMD_SNAP_OFF, ~v, r);
    check("snap bresp", {30'h0, r}, {30'h0, `RESP_OKAY});
    axi_read(`CMD_SNAP_OFF, v2, r);
    check("snap read only", v2, v);
    end_of_test();
  end
endmodule
